// File: hdl/aisar_top.sv
// Purpose: Analog interface glue with decimator latch, gating, modulation, write stall and SAR assist
// Assumes: Analog phase clocks arrive as pins and are synchronised into hclk
// Notes: Functional notes
// Functional notes
// [R1] Two split bits pick latch enable source
// [R2] Terminal count pulse drives decimator latch enable
// [R3] Terminal count raises interrupt; buffer readable anytime
// [R4] Selected PWM gates comparator outputs
// [R5] Four per-column gating enables
// [R6] Dedicated third-clock PWM overrides gate source
// [R7] Modulation picks one of eight sources; the code has seven, with codes 6 and 7 both picking the broadcast bus
// [R8] Modulation bit XORed with stored sign
// [R9] Unsynced writes land any time
// [R10] Sync enable stalls analog writes
// [R11] Release stalled write at phase-one rise
// [R12] Column interrupt option at phase-two fall
// [R13] Top bit of second control type-one only
// [R14] Comparator-to-global enable register
// [R15] Direct column clock bits variant-only
// [R16] Search starts at mid-scale guess
// [R17] Keep bit if low, clear if high
// [R18] Reads override two DAC bits
// [R19] CPU writes read data back unchanged
// [R20] Counter decodes bits operated per read
// [R21] Six bits per sequence
// [R22] Count field loads counter; nonzero means sequence
// [R23] Sign bit inverts accelerator comparator
// [R24] Column select feeds accelerator comparator
// [R25] Comparator latch transparent while phase two high
// [R26] Counter decrements; zero gives plain reads
// [R27] Writes without sync complete at once
`timescale 1ns/1ps
`default_nettype none
module aisar_top
    import aisar_pkg::*;
#(
    parameter logic has_type_one_decim = 1'b1,
    parameter logic has_direct_column_clock_sel = 1'b1,
    parameter logic has_dedicated_pwm = 1'b1
) (
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Async reset, active low
    input wire logic clk_en, // Freezes all state while low
    input wire logic hsel, // Slave select
    input wire logic [7:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire logic phase_one_clock, // Analog phase one, async
    input wire logic phase_two_clock, // Analog phase two, async
    input wire logic [3:0] comparator_raw, // Column comparator outputs, async
    input wire logic [3:0] timer_tc, // Timer primary outputs, same clock
    input wire logic [3:0] pwm_out, // Digital block PWM outputs, same clock
    input wire logic third_pwm_out, // Dedicated PWM on third system clock
    input wire logic [1:0] global_out, // Two global outputs
    input wire logic broadcast_bus, // Digital broadcast bus
    output logic decim_latch_en, // Latch enable to decimator
    output logic decim_irq, // Terminal count interrupt pulse
    output logic [3:0] comparator_bus, // Latched, gated comparator bus
    output logic [3:0] comparator_global, // Comparator onto global bus
    output logic [3:0] sc_sign_out, // Effective sign per column
    output logic column_irq // Phase-two falling edge pulse
);
    logic [1:0] p1_s, p2_s;
    logic [3:0] cmp_s1, cmp_s2;
    logic p1_d, p2_d;
    aisar_dcz_type dcz_r;
    aisar_dco_type dco_r;
    logic [7:0] mod_zero_r, mod_one_r, cmp_ctrl_r, glob_en_r, pwm_ctrl_r;
    aisar_async_type asy_r;
    logic [5:0] dac_code_field_r;
    logic [3:0] sc_sign_bit_r;
    logic [2:0] sar_cnt_r;
    logic [3:0] cmp_latch_r;
    aisar_state_type state_r;
    logic [7:0] addr_r;
    logic wr_r;
    logic [31:0] rdata_r;
    logic dac_seen_r;

    function automatic logic [2:0] mod_choice(input logic [3:0] cb, input logic [1:0] g, input logic b,
                                              input logic [1:0] sel_lo);
        mod_choice = {b, g[sel_lo[0]], cb[sel_lo]};
    endfunction

    // Pins cross into hclk through two flops each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            p1_s <= 2'h0;
            p2_s <= 2'h0;
            cmp_s1 <= 4'h0;
            cmp_s2 <= 4'h0;
            p1_d <= 1'b0;
            p2_d <= 1'b0;
        end else if (clk_en) begin
            p1_s <= {p1_s[0], phase_one_clock};
            p2_s <= {p2_s[0], phase_two_clock};
            cmp_s1 <= comparator_raw;
            cmp_s2 <= cmp_s1;
            p1_d <= p1_s[1];
            p2_d <= p2_s[1];
        end
    end

    wire logic p1_rise = p1_s[1] & ~p1_d;
    wire logic p2_fall = ~p2_s[1] & p2_d;

    // Latch tracks while phase two high; direct-clock option forces transparency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_latch_r <= 4'h0;
        end else if (clk_en) begin
            for (int i = 0; i < 4; i++) begin
                if (p2_s[1] || (has_direct_column_clock_sel && cmp_ctrl_r[1:0] != 2'h0)) begin // [R25] [R15]
                    cmp_latch_r[i] <= cmp_s2[i];
                end
            end
        end
    end

    logic [1:0] latch_sel, gate_sel;
    logic gate_sig;
    assign latch_sel = {dco_r.latch_src_sel_hi, dcz_r.latch_src_sel_lo}; // [R1]
    assign gate_sel = {dco_r.gate_src_sel_hi, dcz_r.gate_src_sel_lo}; // [R4]
    assign gate_sig = (has_dedicated_pwm && pwm_ctrl_r[0]) ? third_pwm_out : pwm_out[gate_sel]; // [R6]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            decim_latch_en <= 1'b0;
            decim_irq <= 1'b0;
            column_irq <= 1'b0;
            comparator_bus <= 4'h0;
            comparator_global <= 4'h0;
            sc_sign_out <= 4'h0;
        end else if (clk_en) begin
            decim_latch_en <= timer_tc[latch_sel]; // [R2]
            decim_irq <= timer_tc[latch_sel]; // [R3]
            column_irq <= p2_fall; // [R12]
            for (int i = 0; i < 4; i++) begin
                comparator_bus[i] <= cmp_latch_r[i] & (~dcz_r.column_gate_enable[i] | gate_sig); // [R5]
                comparator_global[i] <= cmp_latch_r[i] & glob_en_r[i]; // [R14]
            end
            for (int c = 0; c < 4; c++) begin
                logic [2:0] sel;
                logic [2:0] pick;
                logic mbit;
                sel = (c < 2) ? mod_zero_r[3*c +: 3] : mod_one_r[3*(c-2) +: 3];
                pick = mod_choice(cmp_latch_r, global_out, broadcast_bus, sel[1:0]); // [R7]
                mbit = sel[2] ? (sel[1] ? pick[2] : pick[1]) : pick[0];
                sc_sign_out[c] <= sc_sign_bit_r[c] ^ mbit; // [R8]
            end
        end
    end

    // SAR step: bit under test is counter-1, next guess below it
    logic sar_cmp;
    logic [5:0] sar_read;
    assign sar_cmp = cmp_latch_r[asy_r.sar_column] ^ asy_r.sar_sign; // [R24] [R23]
    always_comb begin
        sar_read = dac_code_field_r;
        if (sar_cnt_r != 3'h0 && sar_cnt_r <= 3'(sar_bits)) begin // [R22] [R21]
            if (sar_cmp) begin
                sar_read[sar_cnt_r - 3'h1] = 1'b0; // [R17]
            end
            if (sar_cnt_r > 3'h1) begin
                sar_read[sar_cnt_r - 3'h2] = 1'b1; // [R18] [R20]
            end
        end
    end

    wire logic addr_ok = hsel && hready && htrans[1];
    wire logic is_sc = (haddr == off_dac_reg) || (haddr == off_sc_other);
    wire logic need_stall = addr_ok && hwrite && is_sc && asy_r.write_sync_enable; // [R10]
    wire logic do_write = (state_r == st_data && wr_r) || (state_r == st_stall && p1_rise); // [R11] [R27] [R9]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= st_idle;
            addr_r <= 8'h00;
            wr_r <= 1'b0;
        end else if (clk_en) begin
            case (state_r)
                st_idle, st_data: begin
                    if (state_r == st_stall) begin
                        state_r <= st_stall;
                    end else if (need_stall) begin
                        state_r <= st_stall;
                    end else if (addr_ok) begin
                        state_r <= st_data;
                    end else begin
                        state_r <= st_idle;
                    end
                    if (addr_ok) begin
                        addr_r <= haddr;
                        wr_r <= hwrite;
                    end
                end
                st_stall: begin
                    if (p1_rise) begin
                        state_r <= st_idle;
                        wr_r <= 1'b0;
                    end
                end
                default: state_r <= st_idle;
            endcase
        end
    end

    assign hreadyout = (state_r != st_stall) || p1_rise;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dcz_r <= rst_byte;
            dco_r <= rst_byte;
            mod_zero_r <= rst_byte;
            mod_one_r <= rst_byte;
            asy_r <= rst_byte;
            cmp_ctrl_r <= rst_byte;
            glob_en_r <= rst_byte;
            pwm_ctrl_r <= rst_byte;
            sc_sign_bit_r <= 4'h0;
            dac_code_field_r <= rst_dac; // [R16]
            sar_cnt_r <= rst_count;
        end else if (clk_en) begin
            if (state_r == st_data && !wr_r && addr_r == off_dac_reg && sar_cnt_r != 3'h0) begin
                sar_cnt_r <= sar_cnt_r - 3'h1; // [R26]
            end
            if (do_write) begin
                if (addr_r == off_decim_ctrl_zero) begin
                    dcz_r <= hwdata[7:0];
                end else if (addr_r == off_decim_ctrl_one) begin
                    dco_r <= {hwdata[7] & has_type_one_decim, hwdata[6:0]}; // [R13]
                end else if (addr_r == off_modulation_sel_zero) begin
                    mod_zero_r <= hwdata[7:0];
                end else if (addr_r == off_modulation_sel_one) begin
                    mod_one_r <= hwdata[7:0];
                end else if (addr_r == off_analog_sync_ctrl) begin
                    asy_r <= hwdata[7:0];
                    sar_cnt_r <= hwdata[6:4]; // [R22]
                end else if (addr_r == off_comparator_ctrl_one) begin
                    cmp_ctrl_r <= {hwdata[7:2], hwdata[1:0] & {2{has_direct_column_clock_sel}}}; // [R15]
                end else if (addr_r == off_comparator_global_enable) begin
                    glob_en_r <= {4'h0, hwdata[3:0]};
                end else if (addr_r == off_dac_reg) begin
                    dac_code_field_r <= hwdata[5:0]; // [R19]
                    sc_sign_bit_r[0] <= hwdata[7];
                end else if (addr_r == off_sc_other) begin
                    sc_sign_bit_r[3:1] <= hwdata[2:0];
                end else if (addr_r == off_dedicated_pwm_ctrl) begin
                    pwm_ctrl_r <= {7'h00, hwdata[0] & has_dedicated_pwm};
                end
            end
        end
    end

    // Read data registered at the address phase so the data phase has it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h0;
            dac_seen_r <= 1'b0;
        end else if (clk_en) begin
            dac_seen_r <= 1'b0;
            if (addr_ok && !hwrite && state_r != st_stall) begin
                if (haddr == off_decim_ctrl_zero) begin
                    rdata_r <= {24'h0, dcz_r};
                end else if (haddr == off_decim_ctrl_one) begin
                    rdata_r <= {24'h0, dco_r};
                end else if (haddr == off_modulation_sel_zero) begin
                    rdata_r <= {24'h0, mod_zero_r};
                end else if (haddr == off_modulation_sel_one) begin
                    rdata_r <= {24'h0, mod_one_r};
                end else if (haddr == off_analog_sync_ctrl) begin
                    rdata_r <= {24'h0, asy_r.spare, sar_cnt_r, asy_r[3:0]};
                end else if (haddr == off_comparator_ctrl_one) begin
                    rdata_r <= {24'h0, cmp_ctrl_r};
                end else if (haddr == off_comparator_global_enable) begin
                    rdata_r <= {24'h0, glob_en_r};
                end else if (haddr == off_status) begin
                    rdata_r <= {26'h0, p2_s[1], p1_s[1], cmp_latch_r};
                end else if (haddr == off_dac_reg) begin
                    rdata_r <= {24'h0, sc_sign_bit_r[0], 1'b0, sar_read};
                    dac_seen_r <= 1'b1;
                end else if (haddr == off_sc_other) begin
                    rdata_r <= {29'h0, sc_sign_bit_r[3:1]};
                end else if (haddr == off_dedicated_pwm_ctrl) begin
                    rdata_r <= {24'h0, pwm_ctrl_r};
                end else begin
                    rdata_r <= 32'h0;
                end
            end
        end
    end

    assign hrdata = rdata_r;
endmodule
`default_nettype wire

// File: include/aisar_pkg.sv
// Purpose: Constants and types for the analog interface and SAR assist block
// Assumes: AHB-Lite register access, 32-bit words, 10 MHz hclk
// Notes: Offsets are byte addresses
package aisar_pkg;
    localparam logic [7:0] off_decim_ctrl_zero = 8'h00;
    localparam logic [7:0] off_decim_ctrl_one = 8'h04;
    localparam logic [7:0] off_modulation_sel_zero = 8'h08;
    localparam logic [7:0] off_modulation_sel_one = 8'h0c;
    localparam logic [7:0] off_analog_sync_ctrl = 8'h10;
    localparam logic [7:0] off_comparator_ctrl_one = 8'h14;
    localparam logic [7:0] off_comparator_global_enable = 8'h18;
    localparam logic [7:0] off_status = 8'h1c;
    localparam logic [7:0] off_dac_reg = 8'h20;
    localparam logic [7:0] off_sc_other = 8'h24;
    localparam logic [7:0] off_dedicated_pwm_ctrl = 8'h28;
    localparam logic [7:0] rst_byte = 8'h00;
    localparam logic [5:0] rst_dac = 6'h20;
    localparam logic [2:0] rst_count = 3'h0;
    localparam int sar_bits = 6;
    localparam int clk_hz = 10000000;
    localparam int sync_min_cycles = 1;

    typedef struct packed {
        logic [3:0] column_gate_enable;
        logic gate_src_sel_lo;
        logic latch_src_sel_lo;
        logic [1:0] spare;
    } aisar_dcz_type;

    typedef struct packed {
        logic decim_type_one_bit;
        logic [3:0] spare;
        logic gate_src_sel_hi;
        logic latch_src_sel_hi;
        logic spare0;
    } aisar_dco_type;

    typedef struct packed {
        logic spare;
        logic [2:0] sar_count;
        logic sar_sign;
        logic [1:0] sar_column;
        logic write_sync_enable;
    } aisar_async_type;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_data = 3'b010,
        st_stall = 3'b100
    } aisar_state_type;
endpackage

// File: tb/aisar_assertions.sv
// Purpose: Port-level timing checks for aisar_top
// Assumes: One slave, so hready is the slave's own hreadyout
// Notes: Phase pins pass a two-flop synchroniser, hence the small slack windows
`timescale 1ns/1ps
`default_nettype none
module aisar_assertions
    import aisar_pkg::*;
(
    input wire logic hclk, // Bus clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [7:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic hready, // Bus ready
    input wire logic hreadyout, // Slave ready
    input wire logic phase_one_clock, // Analog phase one
    input wire logic phase_two_clock, // Analog phase two
    input wire logic [3:0] timer_tc, // Timer outputs
    input wire logic decim_latch_en, // Latch enable
    input wire logic decim_irq, // Terminal count interrupt
    input wire logic column_irq // Phase-two fall pulse
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take_r;
    logic take_sc_w;
    assign take_r = hsel && hready && htrans[1] && !hwrite;
    assign take_sc_w = hsel && hready && htrans[1] && hwrite && (haddr == off_dac_reg || haddr == off_sc_other);
    sequence s_stalled_p1_rise;
        $rose(phase_one_clock) && !hreadyout;
    endsequence
    sequence s_release;
        ##[1:6] hreadyout;
    endsequence
    a_latch_cause: assert property (decim_latch_en |-> $past(|timer_tc)) else $error("latch without tc");
    a_irq_latch: assert property (decim_irq == decim_latch_en) else $error("irq and latch differ");
    a_read_no_wait: assert property (take_r |=> hreadyout) else $error("read stalled");
    a_stall_cause: assert property ($fell(hreadyout) |-> $past(take_sc_w)) else $error("stall not sc write");
    a_stall_release: assert property (s_stalled_p1_rise |-> s_release) else $error("stall not released");
    a_stall_phase: assert property ($rose(hreadyout) |-> phase_one_clock) else $error("release off phase");
    a_col_irq_phase: assert property (column_irq |-> !phase_two_clock && $past(phase_two_clock, 6)) else $error("col irq");
    a_col_irq_pulse: assert property (column_irq |=> !column_irq) else $error("col irq too long");
endmodule
bind aisar_top aisar_assertions i_aisar_assertions(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .phase_one_clock(phase_one_clock),
    .phase_two_clock(phase_two_clock), .timer_tc(timer_tc), .decim_latch_en(decim_latch_en),
    .decim_irq(decim_irq), .column_irq(column_irq));
`default_nettype wire

// File: tb/aisar_column_model.sv
// Purpose: Analog column stand-in: two-phase clocks and comparator outputs
// Assumes: Clocks run free and are unrelated to hclk
// Notes: Comparator changes only at phase-one rise, so phase two sees a settled value
`timescale 1ns/1ps
`default_nettype none
module aisar_column_model (
    output logic phase_one_clock, // Phase one
    output logic phase_two_clock, // Phase two
    output logic [3:0] comparator_raw, // Column comparators
    input wire logic [3:0] cmp_level // Level asked by bench
);
    initial begin
        phase_one_clock = 1'b0;
        phase_two_clock = 1'b0;
        comparator_raw = 4'h0;
        forever begin
            // Dead band well above the minimum keeps the phases apart
            #1030 phase_one_clock = 1'b1;
            #1000 phase_one_clock = 1'b0;
            #1030 phase_two_clock = 1'b1;
            #1000 phase_two_clock = 1'b0;
        end
    end
    always @(posedge phase_one_clock) comparator_raw <= cmp_level;
endmodule
`default_nettype wire

// File: tb/aisar_tb_top.sv
// Purpose: Self-checking bench for aisar_top
// Assumes: hready fed back from hreadyout; gating and modulation inputs held idle
// Notes: SAR expectations come from an integer model of the search
`timescale 1ns/1ps
`default_nettype none
module aisar_tb_top;
    import aisar_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clk_en = 1'b1;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic [3:0] timer_tc = 4'h0, cmp_level = 4'h0, comparator_raw, tc;
    logic hreadyout, hresp, decim_latch_en, decim_irq, column_irq, p1, p2;
    int n_fail = 0, check_count = 0, w, s;
    always #50 hclk = ~hclk;
    aisar_top i_aisar_top(.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .phase_one_clock(p1), .phase_two_clock(p2),
        .comparator_raw(comparator_raw), .timer_tc(timer_tc), .pwm_out(4'h0), .third_pwm_out(1'b0),
        .global_out(2'h0), .broadcast_bus(1'b0), .decim_latch_en(decim_latch_en), .decim_irq(decim_irq),
        .comparator_bus(), .comparator_global(), .sc_sign_out(), .column_irq(column_irq));
    aisar_column_model i_aisar_column_model(.phase_one_clock(p1), .phase_two_clock(p2),
        .comparator_raw(comparator_raw), .cmp_level(cmp_level));
    task summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk_bus(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_pin(input logic got, input logic exp);
        chk_bus({31'h0, got}, {31'h0, exp});
    endtask
    // Entered just after a rising edge; ready is sampled at the falling edge so no edge race
    task xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output int nw);
        logic r;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= we;
        r = 1'b0;
        while (!r) begin
            @(negedge hclk);
            r = (hreadyout === 1'b1);
            @(posedge hclk);
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        nw = -1;
        r = 1'b0;
        while (!r) begin
            @(negedge hclk);
            r = (hreadyout === 1'b1);
            rd = hrdata;
            nw++;
            @(posedge hclk);
        end
    endtask
    task sar_pass(input logic [31:0] ctrl);
        int code, n, i;
        logic c;
        logic [3:0] cv;
        xfer(1'b1, off_dac_reg, 32'h20, q, w);
        xfer(1'b1, off_analog_sync_ctrl, ctrl, q, w);
        code = 32;
        n = 6;
        for (i = 0; i < 7; i++) begin
            cv = 4'($urandom);
            cmp_level <= cv;
            repeat (100) @(posedge hclk);
            xfer(1'b0, off_status, 32'h0, q, w);
            chk_bus(q & 32'hf, {28'h0, cv});
            xfer(1'b0, off_dac_reg, 32'h0, q, w);
            c = cv[ctrl[2:1]] ^ ctrl[3];
            if (n > 0 && c)
                code &= ~(1 << (n - 1));
            if (n > 1)
                code |= 1 << (n - 2);
            if (n > 0)
                n--;
            chk_bus(q & 32'h3f, code);
            // Start the write-back inside phase one so a stall cannot end in its first data cycle
            while (p1 !== 1'b1) @(posedge hclk);
            repeat (4) @(posedge hclk);
            xfer(1'b1, off_dac_reg, q | 32'h0, q, w);
            chk_pin(w > 0, ctrl[0]);
        end
    endtask
    initial begin
        w = $urandom(32'h4c406f21);
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b1, 8'h3c, 32'hff, q, w);
        xfer(1'b0, off_analog_sync_ctrl, 32'h0, q, w);
        chk_bus(q, 32'h0);
        xfer(1'b0, off_dac_reg, 32'h0, q, w);
        chk_bus(q, 32'h20);
        xfer(1'b0, 8'h3c, 32'h0, q, w);
        chk_bus(q, 32'h0);
        for (s = 0; s < 4; s++) begin
            xfer(1'b1, off_decim_ctrl_zero, {29'h0, s[0], 2'h0}, q, w);
            xfer(1'b1, off_decim_ctrl_one, {24'h0, 1'b1, 5'h0, s[1], 1'b0}, q, w);
            xfer(1'b0, off_decim_ctrl_one, 32'h0, q, w);
            chk_bus(q, {24'h0, 1'b1, 5'h0, s[1], 1'b0});
            repeat (4) begin
                tc = 4'($urandom);
                timer_tc <= tc;
                @(posedge hclk);
                timer_tc <= 4'h0;
                @(negedge hclk);
                chk_pin(decim_latch_en, tc[s]);
                chk_pin(decim_irq, tc[s]);
                @(posedge hclk);
            end
        end
        // Clock enable low must freeze the latch-enable path
        clk_en <= 1'b0;
        timer_tc <= 4'hf;
        @(posedge hclk);
        timer_tc <= 4'h0;
        @(negedge hclk);
        chk_pin(decim_latch_en, 1'b0);
        @(posedge hclk);
        clk_en <= 1'b1;
        @(posedge hclk);
        // Second pass stalls every DAC write-back and uses the inverted comparator on column 2
        sar_pass(32'h60);
        sar_pass(32'h6d);
        summarize();
    end
    initial begin
        #2000000;
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
